/* File: h2d_cfg.svh */
// Constants for the host-side register frame codec
// Assumes inclusion by bare name from the package and modules
`ifndef H2D_CFG_SVH
`define H2D_CFG_SVH
// ----------------------------------------------------------------------------
// Frame type codes
// ----------------------------------------------------------------------------
`define TYPE_REG_H2D   8'h27
`define TYPE_REG_D2H   8'h34
`define TYPE_DMA_ACT   8'h39
`define TYPE_DMA_SETUP 8'h41
`define TYPE_DATA      8'h46
`define TYPE_BIST      8'h58
`define TYPE_PIO_SETUP 8'h5f
`define TYPE_SDB       8'ha1
`define TYPE_RSV0      8'ha6
`define TYPE_RSV1      8'hb8
`define TYPE_RSV2      8'hbf
`define TYPE_RSV3      8'hd9
`define TYPE_VEND0     8'hc7
`define TYPE_VEND1     8'hd4
// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define FRAME_DWORDS   3'd5
`define C_BIT          7
`define SRST_BIT       2
`define BSY_BIT        7
`define DRQ_BIT        3
`define ERR_BIT        0
`define ABRT_BIT       2
`define ICRC_BIT       7
`define CMD_DEV_RESET  8'h08
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_NS         100
`define BSY_MAX_NS     400
`define BSY_MAX_CYC    (`BSY_MAX_NS / `CLK_NS)
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_FEAT       12'h000
`define OFS_COUNT      12'h004
`define OFS_LBA_LO     12'h008
`define OFS_LBA_HI     12'h00c
`define OFS_DEVICE     12'h010
`define OFS_COMMAND    12'h014
`define OFS_DEVCTL     12'h018
`define OFS_AUX        12'h01c
`define OFS_STATUS     12'h020
`define OFS_RXINFO     12'h024
`define OFS_PMP        12'h028
`endif

/* File: h2d_pkg.sv */
// Types for the host-side register frame codec
// Assumes the cfg header is on the include path
package h2d_pkg;
`include "h2d_cfg.svh"
  typedef enum logic [3:0] {
    CLS_REG_H2D, CLS_REG_D2H, CLS_DMA_ACT, CLS_DMA_SETUP, CLS_DATA, CLS_BIST,
    CLS_PIO_SETUP, CLS_SDB, CLS_RESERVED, CLS_VENDOR, CLS_UNKNOWN
  } fis_class_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} tx_state_t;
endpackage : h2d_pkg

/* File: fis_type_decode.sv */
// Classifies a received frame type byte
// Assumes byte 0 of the first payload word is presented with a strobe
`timescale 1ns/1ps
`include "h2d_cfg.svh"
module fis_type_decode
  import h2d_pkg::*;
(
  input  wire logic [7:0] type_code,
  output fis_class_t      cls,
  output logic            unrec
);
  // --------------------------------------------------------------------------
  // Code map
  // --------------------------------------------------------------------------
  always_comb begin
    case (type_code)
      `TYPE_REG_H2D:   cls = CLS_REG_H2D;
      `TYPE_REG_D2H:   cls = CLS_REG_D2H;
      `TYPE_DMA_ACT:   cls = CLS_DMA_ACT;
      `TYPE_DMA_SETUP: cls = CLS_DMA_SETUP;
      `TYPE_DATA:      cls = CLS_DATA;
      `TYPE_BIST:      cls = CLS_BIST;
      `TYPE_PIO_SETUP: cls = CLS_PIO_SETUP;
      `TYPE_SDB:       cls = CLS_SDB;
      `TYPE_RSV0, `TYPE_RSV1, `TYPE_RSV2, `TYPE_RSV3: cls = CLS_RESERVED;
      `TYPE_VEND0, `TYPE_VEND1: cls = CLS_VENDOR;
      default:         cls = CLS_UNKNOWN;
    endcase
  end
  // Vendor and reserved codes are not accepted here
  assign unrec = (cls == CLS_RESERVED) || (cls == CLS_VENDOR) || (cls == CLS_UNKNOWN);
endmodule : fis_type_decode

/* File: frame_builder.sv */
// Assembles the five-word host-to-device register frame
// Assumes a held shadow snapshot at its inputs
`timescale 1ns/1ps
`include "h2d_cfg.svh"
module frame_builder
  import h2d_pkg::*;
(
  input  wire logic [2:0]  idx,
  input  wire logic        c_bit,
  input  wire logic [3:0]  pmp,
  input  wire logic [15:0] feat,
  input  wire logic [15:0] count,
  input  wire logic [47:0] lba,
  input  wire logic [7:0]  device,
  input  wire logic [7:0]  command,
  input  wire logic [7:0]  devctl,
  input  wire logic [7:0]  icc,
  input  wire logic [31:0] aux,
  output logic [31:0]      dword
);
  // --------------------------------------------------------------------------
  // Word select
  // --------------------------------------------------------------------------
  wire [7:0] flags = {c_bit, 3'h0, pmp};
  always_comb begin
    case (idx)
      3'd0:    dword = {feat[7:0], command, flags, `TYPE_REG_H2D};
      3'd1:    dword = {device, lba[23:0]};
      3'd2:    dword = {feat[15:8], lba[47:24]};
      3'd3:    dword = {devctl, icc, count};
      3'd4:    dword = aux;
      default: dword = 32'h0;
    endcase
  end
endmodule : frame_builder

/* File: reg_fis_host.sv */
// Host adapter shadow register block with register frame transmit and decode
// Assumes a Link layer with valid/ready word stream and an outcome pulse
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "h2d_cfg.svh"
module reg_fis_host
  import h2d_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  input  wire logic        tx_done,
  input  wire logic        tx_err,
  input  wire logic [7:0]  rx_type,
  input  wire logic        rx_type_valid,
  input  wire logic        rx_d2h_valid,
  input  wire logic [7:0]  rx_status,
  input  wire logic [7:0]  rx_error,
  output logic             rx_unrec
);
  // --------------------------------------------------------------------------
  // Shadow registers
  // --------------------------------------------------------------------------
  logic [15:0] feat_r, count_r;
  logic [47:0] lba_r;
  logic [7:0]  device_r, command_r, devctl_r, status_r, error_r, icc_r;
  logic [31:0] aux_r;
  logic [3:0]  pmp_r;
  logic [7:0]  last_type_r;
  logic        last_unrec_r, tx_fail_r;
  logic        pend_r, pend_c_r;
  // Snapshot held for the frame in flight
  logic [15:0] s_feat_r, s_count_r;
  logic [47:0] s_lba_r;
  logic [7:0]  s_device_r, s_command_r, s_devctl_r, s_icc_r;
  logic [31:0] s_aux_r;
  logic [3:0]  s_pmp_r;
  logic        s_c_r;
  tx_state_t   tx_state_r;
  logic [2:0]  idx_r;
  // --------------------------------------------------------------------------
  // AXI write channel
  // --------------------------------------------------------------------------
  logic        aw_have_r, w_have_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  wire         wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;
  wire         busy    = status_r[`BSY_BIT] || status_r[`DRQ_BIT];
  wire         wr_b0   = wstrb_r[0];
  wire [7:0]   wb0     = wdata_r[7:0];
  wire         wr_cmd  = wr_go && awaddr_r == `OFS_COMMAND && wr_b0;
  wire         cmd_ok  = wr_cmd && (!busy || wb0 == `CMD_DEV_RESET);
  wire         wr_ctl  = wr_go && awaddr_r == `OFS_DEVCTL && wr_b0;
  wire         ctl_chg = wr_ctl && wb0 != devctl_r;
  wire         srst_up = wr_ctl && wb0[`SRST_BIT] && !devctl_r[`SRST_BIT];
  wire         tb_lock = busy;
  wire         map_ok  = awaddr_r <= `OFS_PMP && awaddr_r[1:0] == 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= map_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // --------------------------------------------------------------------------
  // Shadow updates
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feat_r <= 16'h0; count_r <= 16'h0; lba_r <= 48'h0; device_r <= 8'h0;
      command_r <= 8'h0; devctl_r <= 8'h0; icc_r <= 8'h0; aux_r <= 32'h0;
      pmp_r <= 4'h0;
    end else if (wr_go) begin
      case (awaddr_r)
        `OFS_FEAT: begin
          if (!tb_lock && wstrb_r[0]) feat_r[7:0] <= wdata_r[7:0];
          if (wstrb_r[1]) feat_r[15:8] <= wdata_r[15:8];
          if (wstrb_r[2]) icc_r <= wdata_r[23:16];
        end
        `OFS_COUNT: begin
          if (!tb_lock && wstrb_r[0]) count_r[7:0] <= wdata_r[7:0];
          if (wstrb_r[1]) count_r[15:8] <= wdata_r[15:8];
        end
        `OFS_LBA_LO: begin
          if (!tb_lock && wstrb_r[0]) lba_r[7:0] <= wdata_r[7:0];
          if (!tb_lock && wstrb_r[1]) lba_r[15:8] <= wdata_r[15:8];
          if (!tb_lock && wstrb_r[2]) lba_r[23:16] <= wdata_r[23:16];
          if (wstrb_r[3]) lba_r[31:24] <= wdata_r[31:24];
        end
        `OFS_LBA_HI: begin
          if (wstrb_r[0]) lba_r[39:32] <= wdata_r[7:0];
          if (wstrb_r[1]) lba_r[47:40] <= wdata_r[15:8];
        end
        `OFS_DEVICE: if (!tb_lock && wr_b0) device_r <= wb0;
        `OFS_COMMAND: if (cmd_ok) command_r <= wb0;
        `OFS_DEVCTL: if (wr_b0) devctl_r <= wb0;
        `OFS_AUX: aux_r <= wdata_r;
        `OFS_PMP: if (wr_b0) pmp_r <= wb0[3:0];
        default: ;
      endcase
    end
  end
  // --------------------------------------------------------------------------
  // Status, receive decode
  // --------------------------------------------------------------------------
  fis_class_t rx_cls;
  logic       rx_unrec_w;
  fis_type_decode u_dec (
    .type_code (rx_type),
    .cls       (rx_cls),
    .unrec     (rx_unrec_w)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 8'h0; error_r <= 8'h0; last_type_r <= 8'h0;
      last_unrec_r <= 1'b0; rx_unrec <= 1'b0;
    end else begin
      rx_unrec <= rx_type_valid && rx_unrec_w;
      if (rx_type_valid) begin
        last_type_r  <= rx_type;
        last_unrec_r <= rx_unrec_w;
      end
      if (cmd_ok || srst_up) begin
        status_r[`BSY_BIT] <= 1'b1;
      end else if (rx_d2h_valid && busy) begin
        status_r <= rx_status;
        error_r  <= rx_error;
      end
    end
  end
  // --------------------------------------------------------------------------
  // Transmit trigger and sequencer
  // --------------------------------------------------------------------------
  wire c_srst_bad = devctl_r[`SRST_BIT];
  wire trig       = cmd_ok || ctl_chg;
  wire trig_c     = cmd_ok;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= 1'b0; pend_c_r <= 1'b0;
    end else if (trig) begin
      pend_r   <= 1'b1;
      pend_c_r <= trig_c;
    end else if (tx_state_r == TX_IDLE && pend_r) begin
      pend_r <= 1'b0;
    end
  end
  wire launch = tx_state_r == TX_IDLE && pend_r && !trig;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_feat_r <= 16'h0; s_count_r <= 16'h0; s_lba_r <= 48'h0; s_device_r <= 8'h0;
      s_command_r <= 8'h0; s_devctl_r <= 8'h0; s_icc_r <= 8'h0; s_aux_r <= 32'h0;
      s_pmp_r <= 4'h0; s_c_r <= 1'b0;
    end else if (launch) begin
      s_feat_r <= feat_r; s_count_r <= count_r; s_lba_r <= lba_r;
      s_device_r <= device_r; s_command_r <= command_r; s_devctl_r <= devctl_r;
      s_icc_r <= icc_r; s_aux_r <= aux_r; s_pmp_r <= pmp_r;
      s_c_r <= pend_c_r && !c_srst_bad;
    end
  end
  wire [2:0] idx_nxt = idx_r + 3'd1;
  wire       take    = tx_valid && tx_ready;
  wire       at_last = idx_r == `FRAME_DWORDS - 3'd1;
  wire       first   = tx_state_r == TX_SEND && !tx_valid;
  wire [2:0] bld_idx = tx_valid ? idx_nxt : idx_r;
  logic [31:0] dword_w;
  frame_builder u_build (
    .idx     (bld_idx),
    .c_bit   (s_c_r),
    .pmp     (s_pmp_r),
    .feat    (s_feat_r),
    .count   (s_count_r),
    .lba     (s_lba_r),
    .device  (s_device_r),
    .command (s_command_r),
    .devctl  (s_devctl_r),
    .icc     (s_icc_r),
    .aux     (s_aux_r),
    .dword   (dword_w)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_r <= TX_IDLE; idx_r <= 3'd0; tx_fail_r <= 1'b0;
    end else begin
      case (tx_state_r)
        TX_IDLE: if (launch) begin
          tx_state_r <= TX_SEND;
          idx_r      <= 3'd0;
        end
        TX_SEND: if (take) begin
          if (idx_r == `FRAME_DWORDS - 3'd1) tx_state_r <= TX_WAIT;
          else idx_r <= idx_nxt;
        end
        TX_WAIT: if (tx_done) begin
          tx_state_r <= TX_IDLE;
          tx_fail_r  <= tx_err;
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end
  // Next word loads on each take, so no word repeats and a stall holds it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid <= 1'b0; tx_last <= 1'b0; tx_data <= 32'h0;
    end else if (first || (take && !at_last)) begin
      tx_valid <= 1'b1;
      tx_last  <= bld_idx == `FRAME_DWORDS - 3'd1;
      tx_data  <= dword_w;
    end else if (take) begin
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
  end
  // --------------------------------------------------------------------------
  // AXI read channel
  // --------------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      `OFS_FEAT:    rd_mux = {8'h0, icc_r, feat_r};
      `OFS_COUNT:   rd_mux = {16'h0, count_r};
      `OFS_LBA_LO:  rd_mux = lba_r[31:0];
      `OFS_LBA_HI:  rd_mux = {16'h0, lba_r[47:32]};
      `OFS_DEVICE:  rd_mux = {24'h0, device_r};
      `OFS_COMMAND: rd_mux = {24'h0, command_r};
      `OFS_DEVCTL:  rd_mux = {24'h0, devctl_r};
      `OFS_AUX:     rd_mux = aux_r;
      `OFS_STATUS:  rd_mux = {14'h0, tx_fail_r, tx_state_r != TX_IDLE, error_r, status_r};
      `OFS_RXINFO:  rd_mux = {23'h0, last_unrec_r, last_type_r};
      `OFS_PMP:     rd_mux = {28'h0, pmp_r};
      default:      rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0; s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= (s_axi_araddr <= `OFS_PMP && s_axi_araddr[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_bsy_after_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_ok |-> ##[1:4] status_r[`BSY_BIT]) else $error("busy late");
  a_bsy_srst: assert property (@(posedge aclk) disable iff (!aresetn)
    srst_up |=> status_r[`BSY_BIT]) else $error("busy not set on reset");
  a_no_c_srst: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && idx_r == 3'd0 |-> !(s_c_r && s_devctl_r[`SRST_BIT])) else $error("C with SRST");
  a_type_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && idx_r == 3'd0 && !tx_last |-> tx_data[7:0] == `TYPE_REG_H2D) else $error("bad type");
  a_rsv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && idx_r == 3'd0 |-> tx_data[14:12] == 3'h0) else $error("reserved nonzero");
  a_snap_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_state_r == TX_WAIT && !tx_done |=> $stable(s_lba_r) && $stable(s_c_r)) else $error("snapshot moved");
  a_stall_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("stream changed");
  a_busy_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_cmd && busy && wb0 != `CMD_DEV_RESET |=> $stable(command_r)) else $error("command taken busy");
  a_unrec_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_type_valid && rx_type == `TYPE_VEND0 |=> rx_unrec) else $error("vendor not flagged");
  c_cmd_frame: cover property (@(posedge aclk) cmd_ok ##[1:20] tx_last);
  c_ctl_frame: cover property (@(posedge aclk) ctl_chg ##[1:20] tx_last);
  c_stall: cover property (@(posedge aclk) tx_valid && !tx_ready);
  c_unrec: cover property (@(posedge aclk) rx_unrec);
endmodule : reg_fis_host

/* File: dev_model.sv */
// Far-end device model: takes frame words, answers with a status frame
// Assumes one frame in flight and a host that waits for tx_done
`timescale 1ns/1ps
module dev_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_valid,
  input  wire logic        tx_last,
  output logic             tx_ready,
  output logic             tx_done,
  output logic             tx_err,
  output logic             rx_d2h_valid,
  output logic [7:0]       rx_status,
  output logic [7:0]       rx_error,
  input  wire logic        crc_mode,
  input  wire logic        stall
);
  logic [31:0] words [0:4];
  logic [2:0]  idx_r;
  int          frames;
  int          wait_r;
  assign tx_err = 1'b0;
  // --------------------------------------------------------------------------
  // Capture, outcome and status reply
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    tx_done <= 1'b0;
    rx_d2h_valid <= 1'b0;
    rx_status <= ~rx_status;
    rx_error <= ~rx_error;
    if (!aresetn) begin
      tx_ready <= 1'b0;
      idx_r <= 3'h0;
      frames <= 0;
      wait_r <= 0;
      rx_status <= 8'h00;
      rx_error <= 8'h00;
    end else begin
      tx_ready <= stall ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        words[idx_r] <= tx_data;
        idx_r <= idx_r + 3'h1;
        if (tx_last) begin
          idx_r <= 3'h0;
          tx_done <= 1'b1;
          frames <= frames + 1;
          wait_r <= 20;
        end
      end
      if (wait_r > 0) wait_r <= wait_r - 1;
      if (wait_r == 1) begin
        rx_d2h_valid <= 1'b1;
        rx_status <= crc_mode ? 8'h01 : 8'h50;
        rx_error <= crc_mode ? 8'h84 : 8'h00;
      end
    end
  end
endmodule : dev_model

/* File: reg_fis_host_tb.sv */
// Testbench for the host register frame codec
// Assumes the cfg header on the include path and the device model
`timescale 1ns/1ps
`include "h2d_cfg.svh"
module reg_fis_host_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, tx_valid, tx_last, tx_ready, tx_done, tx_err, rx_type_valid;
  logic        rx_d2h_valid, rx_unrec, crc_mode, stall;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, tx_data, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]  rx_type, rx_status, rx_error;
  logic [7:0]  codes [15] = '{8'h27, 8'h34, 8'h39, 8'h41, 8'h46, 8'h58, 8'h5f, 8'ha1,
                              8'ha6, 8'hb8, 8'hbf, 8'hd9, 8'hc7, 8'hd4, 8'h00};
  int          err_total, compares;
  reg_fis_host u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_data, .tx_valid, .tx_last, .tx_ready,
    .tx_done, .tx_err, .rx_type, .rx_type_valid, .rx_d2h_valid, .rx_status, .rx_error,
    .rx_unrec);
  dev_model u_dev (.aclk, .aresetn, .tx_data, .tx_valid, .tx_last, .tx_ready, .tx_done,
    .tx_err, .rx_d2h_valid, .rx_status, .rx_error, .crc_mode, .stall);
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 300) begin
      err_total++;
      results();
    end
  endtask : tick
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rdr(input logic [11:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rdr
  task automatic wait_frames(input int f);
    int n;
    n = 0;
    while (u_dev.frames != f) tick(n);
  endtask : wait_frames
  task automatic idle_wait();
    int n;
    n = 0;
    do begin
      rdr(`OFS_STATUS);
      tick(n);
    end while (rd[7] !== 1'b0);
  endtask : idle_wait
  task automatic chk_frame(input logic [31:0] w0, input logic [31:0] w3);
    logic [31:0] e [0:4];
    e = '{w0, 32'h4033_2211, 32'hab66_5544, w3, 32'hdead_beef};
    for (int i = 0; i < 5; i++) chk("frame word", u_dev.words[i], e[i]);
  endtask : chk_frame
  // --------------------------------------------------------------------------
  // Clock and sequence
  // --------------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    err_total = 0;
    compares = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_type, rx_type_valid} = '0;
    {crc_mode, stall} = 2'b00;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(12'h02c);
    chk("unmapped read", {rd[29:0], resp}, 32'h2);
    wr(12'h02c, 32'h0000_0000);
    chk("unmapped write", resp, 32'h2);
    wr(`OFS_FEAT, 32'h005a_ab12);
    wr(`OFS_COUNT, 32'h0000_0102);
    wr(`OFS_LBA_LO, 32'h4433_2211);
    wr(`OFS_LBA_HI, 32'h0000_6655);
    wr(`OFS_DEVICE, 32'h0000_0040);
    wr(`OFS_AUX, 32'hdead_beef);
    wr(`OFS_PMP, 32'h0000_0003);
    chk("pmp write resp", resp, 32'h0);
    wr(`OFS_COMMAND, 32'h0000_0025);
    rdr(`OFS_STATUS);
    chk("busy after command", rd[7], 1'b1);
    wr(`OFS_FEAT, 32'h005a_ab00);
    wr(`OFS_COMMAND, 32'h0000_0030);
    wait_frames(1);
    chk_frame(32'h1225_8327, 32'h005a_0102);
    idle_wait();
    chk("frame count", u_dev.frames, 32'h1);
    wr(`OFS_COMMAND, 32'h0000_0025);
    crc_mode <= 1'b1;
    stall <= 1'b1;
    wr(`OFS_COMMAND, {24'h0, `CMD_DEV_RESET});
    wait_frames(2);
    chk_frame(32'h1225_8327, 32'h005a_0102);
    wait_frames(3);
    chk_frame(32'h1208_8327, 32'h005a_0102);
    idle_wait();
    chk("error reply", rd[17:0], 32'h8401);
    stall <= 1'b0;
    wr(`OFS_DEVCTL, 32'h0000_0004);
    rdr(`OFS_STATUS);
    chk("busy on reset rise", rd[7], 1'b1);
    wait_frames(4);
    chk_frame(32'h1208_0327, 32'h045a_0102);
    idle_wait();
    wr(`OFS_DEVCTL, 32'h0000_0004);
    wr(`OFS_DEVCTL, 32'h0000_0006);
    rdr(`OFS_STATUS);
    chk("no busy without rise", rd[7], 1'b0);
    wait_frames(5);
    chk_frame(32'h1208_0327, 32'h065a_0102);
    foreach (codes[i]) begin
      rx_type <= codes[i];
      rx_type_valid <= 1'b1;
      @(posedge aclk);
      rx_type_valid <= 1'b0;
      @(posedge aclk);
      chk("unrec flag", rx_unrec, i > 7);
    end
    rdr(`OFS_RXINFO);
    chk("last type", rd[8:0], 32'h100);
    results();
  end
endmodule : reg_fis_host_tb
